// *** fkt_pkg.sv ***
// Constants, register map and carrier types for the keying and trip logic.
// Assumes a 200 MHz system clock and APB register access with 32-bit data.
`default_nettype none
package fkt_pkg;
   // Clock and the 1 ms timer tick.
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 1_000_000;
   localparam int TICK_CYCLES_DEF = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Millisecond counter width and the fixed receiver times in ms.
   localparam int MSW = 11;
   localparam logic [MSW-1:0] GBT_MS = 11'h078;
   localparam logic [MSW-1:0] TAG_MS = 11'h078;
   localparam logic [MSW-1:0] OVR_TRIP_MS = 11'h3E8;
   localparam logic [MSW-1:0] OVR_RESET_MS = 11'h0C8;
   localparam logic [MSW-1:0] MS_MAX = 11'h7FF;
   // Register byte offsets.
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_TIMING = 12'h004;
   localparam logic [11:0] ADDR_UNBLOCK = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   // Control fields.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WIDE_BIT = 4;
   localparam int CTRL_GBT_LSB = 8;
   // Timing fields.
   localparam int TIM_PRE_LSB = 0;
   localparam int TIM_THOLD_LSB = 8;
   localparam int TIM_GHOLD_LSB = 16;
   // Unblock fields.
   localparam int UB_WIN_LSB = 0;
   localparam int UB_DLY_LSB = 16;
   // Reset values of the settings.
   localparam logic [4:0] PRE_RST = 5'h00;
   localparam logic [6:0] HOLD_RST = 7'h00;
   localparam logic [8:0] UBWIN_RST = 9'h000;
   localparam logic [6:0] UBDLY_RST = 7'h00;
   // Four-frequency tone offsets from center, narrow shift, in Hz.
   localparam logic signed [10:0] OFS_OUTER = 11'sh0F9;
   localparam logic signed [10:0] OFS_INNER = 11'sh053;

   typedef enum logic [2:0] {
      MODE_ONOFF_CSS, MODE_DC2, MODE_DC3, MODE_PC2, MODE_SUT2, MODE_F4
   } fkt_mode_t;
   typedef enum logic [1:0] {GBT_OFF, GBT_ON, GBT_OVERRIDE} fkt_gbt_t;
   typedef enum logic [3:0] {
      TONE_NONE, TONE_CARRIER, TONE_LOWER, TONE_UPPER, TONE_CENTER,
      TONE_BOTH_CMD, TONE_CMD_B, TONE_GUARD, TONE_CMD_A
   } fkt_tone_t;

   // Keying and receiver pins.
   typedef struct packed {
      logic transferTripKey;
      logic lineRelayKey;
      logic transmitInhibit;
      logic breakerOpenAux;
      logic phaseCompareKey;
      logic levelRaise;
      logic unblockKey;
      logic startKey;
      logic stopKey;
      logic lowLevelKey;
      logic checkbackTx;
      logic rxGuard;
      logic rxTrip;
      logic rxLowLevel;
   } fkt_pins_t;

   // Transmitter selection.
   typedef struct packed {
      logic txOn;
      logic levelHigh;
      fkt_tone_t tone;
      logic signed [10:0] offsetHz;
      logic checkbackAllowed;
   } fkt_tx_t;

   // Receiver outputs.
   typedef struct packed {
      logic trip;
      logic guard;
      logic checkbackTrip;
      logic unblockTrip;
   } fkt_rx_t;
endpackage
`default_nettype wire

// *** fkt_keying_trip.sv ***
// FSK keying tables and two-frequency trip/guard receive decision.
// Assumes synchronous APB master on mclk and asynchronous pins on the key and rx inputs.
//
// Behaviour
// R01 - Start/stop single-lead keying map applies only with that option selected.
// R02 - Transfer-trip or unblock function uses the two-frequency directional map.
// R03 - Combined channel uses three-frequency map; transfer trip key wins over line relay.
// R04 - Phase comparison: lower tone when keyed, else upper; raise input picks high level.
// R05 - Shift up: upper tone high when keyed, else lower tone, high with breaker aux.
// R06 - Four-frequency: both, A, B tones at high level; guard tone low otherwise.
// R07 - Four-frequency guard tone stays low level whatever the raise or aux input.
// R08 - Transmit inhibit turns output off in every mode, above all keys.
// R09 - Four-frequency tone offsets 249/83 Hz, doubled with wide shift.
// R10 - Guard-before-trip needs 120 ms continuous guard after signal loss.
// R11 - Guard-before-trip is off, on, or on with override.
// R12 - Losing guard locks out tripping unless trip arrives within 120 ms.
// R13 - Trip and guard hold timers 1 to 100 ms; zero disables.
// R14 - Hold timers stretch outputs only, never internal decision state.
// R15 - Pre-trip delay of 0 to 30 ms before trip output.
// R16 - Trip over 1000 ms with override waives guard-before-trip.
// R17 - Open-breaker override clears after 200 ms of restored guard.
// R18 - Loss of channel gives unblock trip for 1 to 500 ms window; zero disables.
// R19 - After the unblock window, lock out until 120 ms of guard.
// R20 - Unblock trip assertion may be delayed 1 to 100 ms; zero means none.
// R21 - Checkback trip asserts whenever trip asserts.
// R22 - Trip tone after channel loss without guard gives checkback trip only.
// R23 - Directional map: lower tone high when keyed, else upper, high with aux.
// R24 - Three-frequency: lower for transfer trip, upper for line relay, else center.
// R25 - Loss of channel is low received level together with no guard.
// R26 - Millisecond timers count a 1 ms tick and restart when their condition drops.
// R27 - Keying inputs are synchronised and selection updates the next cycle.
`default_nettype none
module fkt_keying_trip
   import fkt_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic mclk, // System clock, 200 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire fkt_pins_t pins, // Asynchronous keying and receiver pins.
   output fkt_tx_t txSel, // Selected tone and level.
   output fkt_rx_t rxOut // Trip, guard and checkback outputs.
);

   typedef struct packed {
      fkt_pins_t s1;
      fkt_pins_t s2;
      fkt_pins_t s3;
      fkt_pins_t pin;
      fkt_mode_t mode;
      logic wide;
      fkt_gbt_t gbt;
      logic [4:0] preMsSet;
      logic [6:0] tripHoldSet;
      logic [6:0] guardHoldSet;
      logic [8:0] ubWinSet;
      logic [6:0] ubDlySet;
      logic [17:0] tickCnt;
      logic tick;
      logic [MSW-1:0] guardMs;
      logic [MSW-1:0] tripMs;
      logic [MSW-1:0] noGuardMs;
      logic [MSW-1:0] locMs;
      logic [MSW-1:0] preMs;
      logic gbtHave;
      logic openBrk;
      logic tripSeen;
      logic tagLock;
      logic ubLock;
      logic locPending;
      logic [6:0] tripHoldMs;
      logic [6:0] guardHoldMs;
      fkt_tx_t tx;
      fkt_rx_t rx;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fkt_state_t;

   fkt_state_t q;
   fkt_state_t d;

   // Saturating millisecond increment.
   function automatic logic [MSW-1:0] msInc(input logic [MSW-1:0] v);
      msInc = (v == MS_MAX) ? v : v + 11'h001;
   endfunction

   // Register index of an APB address; 3'h7 marks an unmapped address.
   function automatic logic [2:0] regIndex(input logic [11:0] a);
      case (a)
         ADDR_CTRL: regIndex = 3'h0;
         ADDR_TIMING: regIndex = 3'h1;
         ADDR_UNBLOCK: regIndex = 3'h2;
         ADDR_STATUS: regIndex = 3'h3;
         default: regIndex = 3'h7;
      endcase
   endfunction

   // Builds a tone selection at a given level.
   function automatic fkt_tx_t sendTone(input fkt_tone_t t, input logic hi, input logic signed [10:0] ofs);
      sendTone = '0;
      sendTone.txOn = 1'b1;
      sendTone.levelHigh = hi;
      sendTone.tone = t;
      sendTone.offsetHz = ofs;
   endfunction

   // Keying table for every channel mode.
   function automatic fkt_tx_t keyMap(input fkt_pins_t p, input fkt_mode_t m, input logic w);
      logic signed [10:0] outer;
      logic signed [10:0] inner;
      outer = w ? (OFS_OUTER <<< 1) : OFS_OUTER; // R09
      inner = w ? (OFS_INNER <<< 1) : OFS_INNER; // R09
      keyMap = '0;
      case (m)
         MODE_ONOFF_CSS: begin
            // Single-lead start/stop map.
            if (p.startKey && !p.stopKey) begin
               keyMap = sendTone(TONE_CARRIER, 1'b1, 11'sh000); // R01
            end else if (p.startKey && p.lowLevelKey) begin
               keyMap = sendTone(TONE_CARRIER, 1'b0, 11'sh000); // R01
            end else begin
               keyMap.checkbackAllowed = p.startKey && p.stopKey && p.checkbackTx; // R01
            end
         end
         MODE_DC2: begin
            if (p.transferTripKey || p.unblockKey) begin
               keyMap = sendTone(TONE_LOWER, 1'b1, 11'sh000); // R02 R23
            end else begin
               keyMap = sendTone(TONE_UPPER, p.breakerOpenAux, 11'sh000); // R23
            end
         end
         MODE_DC3: begin
            if (p.transferTripKey) begin
               keyMap = sendTone(TONE_LOWER, 1'b1, 11'sh000); // R03 R24
            end else if (p.lineRelayKey) begin
               keyMap = sendTone(TONE_UPPER, 1'b1, 11'sh000); // R24
            end else begin
               keyMap = sendTone(TONE_CENTER, p.breakerOpenAux, 11'sh000); // R24
            end
         end
         MODE_PC2: begin
            keyMap = sendTone(p.phaseCompareKey ? TONE_LOWER : TONE_UPPER, p.levelRaise, 11'sh000); // R04
         end
         MODE_SUT2: begin
            if (p.transferTripKey || p.unblockKey) begin
               keyMap = sendTone(TONE_UPPER, 1'b1, 11'sh000); // R05
            end else begin
               keyMap = sendTone(TONE_LOWER, p.breakerOpenAux, 11'sh000); // R05
            end
         end
         MODE_F4: begin
            if (p.transferTripKey && p.lineRelayKey) begin
               keyMap = sendTone(TONE_BOTH_CMD, 1'b1, -outer); // R06
            end else if (p.transferTripKey) begin
               keyMap = sendTone(TONE_CMD_A, 1'b1, outer); // R06
            end else if (p.lineRelayKey) begin
               keyMap = sendTone(TONE_CMD_B, 1'b1, -inner); // R06
            end else begin
               keyMap = sendTone(TONE_GUARD, 1'b0, inner); // R06 R07
            end
         end
         default: keyMap = '0;
      endcase
      if (p.transmitInhibit) begin
         keyMap = '0; // R08
      end
   endfunction

   // Next-state logic for the bus, keying and receiver.
   always_comb begin
      logic guard;
      logic trip;
      logic loc;
      logic gbtMet;
      logic gbtOk;
      logic ubActive;
      logic decision;
      logic qualified;
      logic cbRaw;
      logic access;
      logic [2:0] idx;
      logic [MSW-1:0] ubStart;
      logic [MSW-1:0] ubEnd;
      d = q;
      guard = q.pin.rxGuard;
      trip = q.pin.rxTrip;
      loc = q.pin.rxLowLevel && !guard; // R25
      gbtMet = q.guardMs >= GBT_MS;
      ubStart = MSW'(q.ubDlySet);
      ubEnd = MSW'(q.ubDlySet) + MSW'(q.ubWinSet);

      // Three-stage pin synchroniser; a bit is taken once stages two and three agree.
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < $bits(fkt_pins_t); i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.pin[i] = q.s3[i]; // R27
         end
      end

      // One-cycle 1 ms tick.
      d.tick = 1'b0;
      if (q.tickCnt == 18'(TICK_CYCLES - 1)) begin
         d.tickCnt = '0;
         d.tick = 1'b1; // R26
      end else begin
         d.tickCnt = q.tickCnt + 18'h0_0001;
      end

      // Keying selection, one cycle after the synchronised input changes.
      d.tx = keyMap(q.pin, q.mode, q.wide); // R27

      // Millisecond condition timers restart as soon as their condition drops.
      if (!guard) begin
         d.guardMs = '0; // R26
      end else if (q.tick) begin
         d.guardMs = msInc(q.guardMs);
      end
      if (!trip) begin
         d.tripMs = '0; // R26
      end else if (q.tick) begin
         d.tripMs = msInc(q.tripMs);
      end
      if (guard) begin
         d.noGuardMs = '0; // R26
      end else if (q.tick) begin
         d.noGuardMs = msInc(q.noGuardMs);
      end
      if (!loc) begin
         d.locMs = '0; // R26
      end else if (q.tick) begin
         d.locMs = msInc(q.locMs);
      end

      // Guard-before-trip: signal loss clears it, 120 ms of guard restores it.
      if (gbtMet) begin
         d.gbtHave = 1'b1; // R10
      end else if (loc) begin
         d.gbtHave = 1'b0; // R10
      end

      // Open-breaker override; setting by long trip wins over the guard reset.
      if (q.gbt == GBT_OVERRIDE && q.tripMs > OVR_TRIP_MS) begin
         d.openBrk = 1'b1; // R16
      end else if (q.guardMs >= OVR_RESET_MS || q.gbt != GBT_OVERRIDE) begin
         d.openBrk = 1'b0; // R17
      end

      // Trip-after-guard lockout.
      if (trip) begin
         d.tripSeen = 1'b1;
      end else if (guard) begin
         d.tripSeen = 1'b0;
      end
      if (!guard && !q.tripSeen && !trip && q.noGuardMs >= TAG_MS) begin
         d.tagLock = 1'b1; // R12
      end else if (gbtMet) begin
         d.tagLock = 1'b0; // R12
      end

      // Unblock window after channel loss, then lockout until 120 ms of guard.
      ubActive = (q.ubWinSet != '0) && loc && !q.ubLock && q.locMs >= ubStart && q.locMs < ubEnd; // R18 R20
      if (q.ubWinSet != '0 && loc && q.locMs >= ubEnd) begin
         d.ubLock = 1'b1; // R19
      end else if (gbtMet) begin
         d.ubLock = 1'b0; // R19
      end

      // Channel loss not yet followed by guard return.
      if (loc) begin
         d.locPending = 1'b1;
      end else if (guard) begin
         d.locPending = 1'b0;
      end

      // Trip decision.
      gbtOk = (q.gbt == GBT_OFF) || q.gbtHave || (q.gbt == GBT_OVERRIDE && q.openBrk); // R11 R16
      decision = ubActive ||
         (trip && gbtOk && !q.tagLock && !q.ubLock && (!q.locPending || q.openBrk)); // R10 R22

      // Pre-trip qualification.
      if (!decision) begin
         d.preMs = '0; // R26
      end else if (q.tick) begin
         d.preMs = msInc(q.preMs);
      end
      qualified = decision && q.preMs >= MSW'(q.preMsSet); // R15
      cbRaw = qualified || (trip && q.locPending && !q.openBrk); // R22

      // Output hold timers act on the output copies only.
      if (qualified) begin
         d.tripHoldMs = q.tripHoldSet; // R13 R14
      end else if (q.tick && q.tripHoldMs != '0) begin
         d.tripHoldMs = q.tripHoldMs - 7'h01;
      end
      if (guard) begin
         d.guardHoldMs = q.guardHoldSet; // R13 R14
      end else if (q.tick && q.guardHoldMs != '0) begin
         d.guardHoldMs = q.guardHoldMs - 7'h01;
      end
      d.rx.trip = qualified || (q.tripHoldMs != '0); // R13
      d.rx.guard = guard || (q.guardHoldMs != '0); // R13
      d.rx.checkbackTrip = cbRaw || d.rx.trip; // R21
      d.rx.unblockTrip = ubActive && qualified;

      // APB slave: the access phase takes two cycles, answered with pready.
      access = psel && penable && !q.pready;
      idx = regIndex(paddr);
      d.pready = access;
      d.pslverr = access && (idx == 3'h7);
      if (access) begin
         d.prdata = '0;
         case (idx)
            3'h0: begin
               d.prdata[CTRL_MODE_LSB +: 3] = q.mode;
               d.prdata[CTRL_WIDE_BIT] = q.wide;
               d.prdata[CTRL_GBT_LSB +: 2] = q.gbt;
            end
            3'h1: begin
               d.prdata[TIM_PRE_LSB +: 5] = q.preMsSet;
               d.prdata[TIM_THOLD_LSB +: 7] = q.tripHoldSet;
               d.prdata[TIM_GHOLD_LSB +: 7] = q.guardHoldSet;
            end
            3'h2: begin
               d.prdata[UB_WIN_LSB +: 9] = q.ubWinSet;
               d.prdata[UB_DLY_LSB +: 7] = q.ubDlySet;
            end
            3'h3: begin
               d.prdata[0] = q.rx.trip;
               d.prdata[1] = q.rx.guard;
               d.prdata[2] = q.rx.checkbackTrip;
               d.prdata[3] = q.rx.unblockTrip;
               d.prdata[4] = q.gbtHave;
               d.prdata[5] = q.openBrk;
               d.prdata[6] = q.tagLock;
               d.prdata[7] = q.ubLock;
               d.prdata[8] = q.locPending;
               d.prdata[9] = q.tx.txOn;
               d.prdata[10] = q.tx.levelHigh;
               d.prdata[15:12] = q.tx.tone;
               d.prdata[26:16] = q.tx.offsetHz;
            end
            default: d.prdata = '0;
         endcase
      end
      if (psel && penable && q.pready && pwrite) begin
            case (idx)
               3'h0: begin
                  d.mode = fkt_mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
                  d.wide = pwdata[CTRL_WIDE_BIT];
                  d.gbt = fkt_gbt_t'(pwdata[CTRL_GBT_LSB +: 2]); // R11
               end
               3'h1: begin
                  d.preMsSet = pwdata[TIM_PRE_LSB +: 5];
                  d.tripHoldSet = pwdata[TIM_THOLD_LSB +: 7];
                  d.guardHoldSet = pwdata[TIM_GHOLD_LSB +: 7];
               end
               3'h2: begin
                  d.ubWinSet = pwdata[UB_WIN_LSB +: 9];
                  d.ubDlySet = pwdata[UB_DLY_LSB +: 7];
               end
               default: d.ubDlySet = q.ubDlySet;
            endcase
      end
   end

   // State register.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.mode <= MODE_DC2;
         q.gbt <= GBT_OFF;
         q.preMsSet <= PRE_RST;
         q.tripHoldSet <= HOLD_RST;
         q.guardHoldSet <= HOLD_RST;
         q.ubWinSet <= UBWIN_RST;
         q.ubDlySet <= UBDLY_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register.
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign txSel = q.tx;
   assign rxOut = q.rx;

endmodule
`default_nettype wire

// *** fkt_relay_model.sv ***
// Relay model driving the block's pins.
// Assumes the bench sets the levels.
`default_nettype none
module fkt_relay_model
   import fkt_pkg::*;
(
   input wire logic mclk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire fkt_pins_t keyReq, // Levels the relay wants on the pins.
   input wire logic slow, // High for a relay that answers a cycle late.
   output var fkt_pins_t pins // Levels driven to the block.
);
   fkt_pins_t lag_q;

   // Contacts change just after a clock edge, either promptly or one cycle late.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lag_q <= '0;
         pins <= '0;
      end else begin
         lag_q <= keyReq;
         pins <= slow ? lag_q : keyReq;
      end
   end
endmodule
`default_nettype wire

// *** fkt_keying_trip_checker.sv ***
// Checker for the keying and trip logic, bound to its top module.
// Assumes one APB wait state.
`default_nettype none
module fkt_keying_trip_checker
   import fkt_pkg::*;
(
   input wire logic mclk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [31:0] prdata, // APB read data.
   input wire logic pready, // APB ready.
   input wire logic pslverr, // APB error.
   input wire fkt_pins_t pins, // Keying and receiver pins.
   input wire fkt_tx_t txSel, // Tone and level selection.
   input wire fkt_rx_t rxOut // Receiver outputs.
);
   // All checks run on mclk and pause while reset is low.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Bus answer timing and refusal.
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("No ready after wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("Ready longer than a cycle");
   a_err_empty: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("Bad error answer");

   // Transmit selection relations.
   a_inhibit_off: assert property (pins.transmitInhibit [*8] |-> !txSel.txOn && txSel.tone == TONE_NONE)
      else $error("Transmitter on while inhibited");
   a_guard_low: assert property (txSel.tone == TONE_GUARD |->
      !txSel.levelHigh && (txSel.offsetHz == OFS_INNER || txSel.offsetHz == (OFS_INNER <<< 1)))
      else $error("Bad guard tone");
   a_cmd_high: assert property (txSel.tone inside {TONE_BOTH_CMD, TONE_CMD_A, TONE_CMD_B} |-> txSel.levelHigh)
      else $error("Command tone low");
   a_outer_offset: assert property (txSel.tone == TONE_BOTH_CMD |->
      txSel.offsetHz == -OFS_OUTER || txSel.offsetHz == -(OFS_OUTER <<< 1))
      else $error("Bad both-commands offset");

   // Receiver outputs.
   a_cb_trip: assert property (rxOut.trip |-> rxOut.checkbackTrip)
      else $error("Trip without checkback trip");

   // Main scenarios seen.
   c_write: cover property (psel && penable && pready && pwrite);
   c_error: cover property (pslverr);
   c_unblock: cover property (rxOut.unblockTrip);
   c_trip: cover property (rxOut.trip && rxOut.checkbackTrip);
endmodule

bind fkt_keying_trip fkt_keying_trip_checker fkt_keying_trip_checker_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .txSel(txSel), .rxOut(rxOut));
`default_nettype wire

// *** fkt_keying_trip_tb.sv ***
// Bench for the keying and trip logic.
// Assumes the relay model on the pins and a ten-cycle tick.
`default_nettype none
module fkt_keying_trip_tb import fkt_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 10;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err;
   fkt_pins_t keyReq = '0, pins;
   fkt_tx_t txSel;
   fkt_rx_t rxOut;
   int n_errors = 0, check_count = 0;
   logic [2:0] modes [7] = '{MODE_DC2, MODE_DC3, MODE_PC2, MODE_SUT2, MODE_F4, MODE_F4, MODE_ONOFF_CSS};

   // Clock at 200 MHz.
   always #2.5 mclk = ~mclk;

   // Design with a short tick, relay in front.
   fkt_keying_trip #(.TICK_CYCLES(TICK)) fkt_keying_trip_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .txSel(txSel), .rxOut(rxOut));
   fkt_relay_model fkt_relay_model_i (.mclk(mclk), .rst_n(rst_n), .keyReq(keyReq), .slow(slow), .pins(pins));

   // Comparison and verdict.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check1(input string what, input logic seen, input logic exp);
      check(what, {31'h0000_0000, seen}, {31'h0000_0000, exp});
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One APB transfer; data taken at the ready edge.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         n_errors++;
         complete_run();
      end
   endtask
   task automatic ms(input int n);
      repeat (n * TICK) @(posedge mclk);
   endtask
   // Guard, trip, low level for n ms.
   task automatic rx(input logic [2:0] gtl, input int n);
      @(posedge mclk);
      {keyReq.rxGuard, keyReq.rxTrip, keyReq.rxLowLevel} <= gtl;
      ms(n);
   endtask
   task automatic cfg(input logic [1:0] gbt, input logic [31:0] tim, input logic [31:0] ub);
      apb(1'b1, ADDR_CTRL, {22'h00_0000, gbt, 8'h01});
      apb(1'b1, ADDR_TIMING, tim);
      apb(1'b1, ADDR_UNBLOCK, ub);
   endtask

   // Expected txSel[17:1]; b is {key, second key, inhibit, aux or raise}.
   function automatic logic [16:0] expTx(input logic [2:0] m, input logic wide, input logic [3:0] b);
      fkt_tone_t t;
      logic hi;
      logic signed [10:0] o;
      o = 11'sh000;
      t = b[3] ? TONE_LOWER : TONE_UPPER;
      hi = b[3] | b[0];
      case (m)
         MODE_SUT2: t = b[3] ? TONE_UPPER : TONE_LOWER;
         MODE_PC2: hi = b[0];
         MODE_DC3: begin
            t = b[3] ? TONE_LOWER : (b[2] ? TONE_UPPER : TONE_CENTER);
            hi = b[3] | b[2] | b[0];
         end
         MODE_F4: begin
            t = b[3] ? (b[2] ? TONE_BOTH_CMD : TONE_CMD_A) : (b[2] ? TONE_CMD_B : TONE_GUARD);
            o = b[3] ? (b[2] ? -OFS_OUTER : OFS_OUTER) : (b[2] ? -OFS_INNER : OFS_INNER);
            hi = b[3] | b[2];
         end
         default: ;
      endcase
      if (wide) o = o <<< 1;
      if (b[1]) return 17'h0_0000;
      return {1'b1, hi, t, o};
   endfunction

   // Main sequence.
   initial begin
      int m, b;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, ADDR_CTRL, '0);
      check("ctrl reset", rd, 32'h0000_0001);
      apb(1'b0, ADDR_TIMING, '0);
      check("timing reset", rd, '0);
      apb(1'b0, ADDR_UNBLOCK, '0);
      check("unblock reset", rd, '0);
      apb(1'b0, 12'h010, '0);
      check1("unmapped error", err, 1'b1);
      check("unmapped data", rd, '0);
      apb(1'b1, ADDR_CTRL, 32'h0000_0201);
      apb(1'b0, ADDR_CTRL, '0);
      check("ctrl override", rd, 32'h0000_0201);
      // All sixteen key patterns in all modes, only the eight without inhibit checked in start/stop; relay prompt and slow.
      for (m = 0; m < 7; m++) begin
         apb(1'b1, ADDR_CTRL, {27'h000_0000, m == 5, 1'b0, modes[m]});
         slow <= m[0];
         for (b = 0; b < 16; b++) begin
            @(posedge mclk);
            keyReq <= {b[3], b[2], b[1], b[0], b[3], b[0], b[3], b[3], b[2], b[0], 4'h0};
            repeat (12) @(posedge mclk);
            if (m < 6) begin
               check("tx select", 32'(txSel[17:1]),
                  32'(expTx(modes[m], m == 5, b[3:0])));
            end else if (b[1] == 1'b0) begin
               check("start stop", 32'({txSel.txOn, txSel.levelHigh}),
                  (b[3] && !b[2]) ? 32'h0000_0003 : (b[3] && b[2] && b[0]) ? 32'h0000_0002 : 32'h0000_0000);
            end
         end
      end
      keyReq <= '0;
      // Guard before trip, pre-trip, trip hold.
      cfg(2'd1, '0, '0);
      rx(3'b100, 150);
      check1("guard out", rxOut.guard, 1'b1);
      rx(3'b010, 3);
      check1("trip", rxOut.trip, 1'b1);
      check1("checkback", rxOut.checkbackTrip, 1'b1);
      cfg(2'd1, 32'h0000_0A05, '0);
      rx(3'b100, 150);
      rx(3'b010, 2);
      check1("pre-trip early", rxOut.trip, 1'b0);
      ms(6);
      check1("pre-trip late", rxOut.trip, 1'b1);
      rx(3'b100, 4);
      check1("hold on", rxOut.trip, 1'b1);
      ms(10);
      check1("hold off", rxOut.trip, 1'b0);
      // Late trip after guard loss.
      cfg(2'd1, '0, '0);
      rx(3'b100, 150);
      rx(3'b000, 130);
      rx(3'b010, 10);
      check1("late trip", rxOut.trip, 1'b0);
      // Unblock window, lockout, delay.
      cfg(2'd0, '0, 32'h0000_0014);
      rx(3'b100, 150);
      rx(3'b001, 5);
      check1("unblock on", rxOut.unblockTrip, 1'b1);
      ms(30);
      check1("unblock off", rxOut.unblockTrip, 1'b0);
      rx(3'b100, 50);
      rx(3'b010, 5);
      check1("locked out", rxOut.trip, 1'b0);
      cfg(2'd0, '0, 32'h000A_0014);
      rx(3'b100, 150);
      rx(3'b001, 4);
      check1("unblock delayed", rxOut.unblockTrip, 1'b0);
      ms(10);
      check1("unblock after delay", rxOut.unblockTrip, 1'b1);
      // Trip after channel loss: checkback only.
      cfg(2'd1, '0, '0);
      rx(3'b100, 150);
      rx(3'b001, 5);
      rx(3'b010, 5);
      check1("loss trip", rxOut.trip, 1'b0);
      check1("loss checkback", rxOut.checkbackTrip, 1'b1);
      // Open-breaker override and its reset.
      cfg(2'd2, '0, '0);
      rx(3'b100, 150);
      rx(3'b010, 1100);
      rx(3'b001, 5);
      rx(3'b010, 5);
      check1("override trip", rxOut.trip, 1'b1);
      rx(3'b100, 250);
      rx(3'b001, 5);
      rx(3'b010, 5);
      check1("override reset", rxOut.trip, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
